//--- core/usb_device_endpoint_status_irq.sv
/*
 * Endpoint status and interrupt register bank of a full-speed USB device,
 * reached over AXI4-Lite, updated by the protocol engine.
 * Assumes engine strobes come from logic on core_clk_i, one cycle each,
 * and that the bus master keeps one read and one write in flight at most.
 */
`timescale 1ns/1ps
`include "usb_ep_defines.svh"

module usb_device_endpoint_status_irq (
   // Clock, reset, enable
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   // AXI4-Lite write address
   input  wire logic       s_axi_awvalid_i,
   output logic            s_axi_awready_o,
   input  wire logic [11:0] s_axi_awaddr_i,
   // AXI4-Lite write data
   input  wire logic       s_axi_wvalid_i,
   output logic            s_axi_wready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0] s_axi_wstrb_i,
   // AXI4-Lite write response
   output logic            s_axi_bvalid_o,
   input  wire logic       s_axi_bready_i,
   output logic [1:0]      s_axi_bresp_o,
   // AXI4-Lite read address
   input  wire logic       s_axi_arvalid_i,
   output logic            s_axi_arready_o,
   input  wire logic [11:0] s_axi_araddr_i,
   // AXI4-Lite read data
   output logic            s_axi_rvalid_o,
   input  wire logic       s_axi_rready_i,
   output logic [31:0]     s_axi_rdata_o,
   output logic [1:0]      s_axi_rresp_o,
   // Protocol engine events, one-cycle strobes, and the endpoint enable level
   input  wire logic       usb_bus_reset_i,
   input  wire logic       endpoint_enable_vector_i,
   input  wire logic       setup_rx_i,
   input  wire logic       stall_sent_i,
   input  wire logic       xfer_fail_i,
   input  wire logic       xfer_done_i,
   input  wire logic [7:0] status_hw_set_i,
   input  wire logic [7:0] status_hw_clr_i,
   // Status towards the protocol engine
   output logic [1:0]      stall_request_o,
   output logic            current_bank_select_o,
   output logic            in_toggle_o,
   output logic            out_toggle_o,
   output logic [1:0]      bank_ready_o,
   // Endpoint interrupt request
   output logic            endpoint_irq_o
);
   import usb_ep_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   ep_state_t  st;           // Registered state
   ep_state_t  next_st;      // Next state
   logic       aw_fire;      // Write address handshake this cycle
   logic       w_fire;       // Write data handshake this cycle
   logic       ar_fire;      // Read address handshake this cycle
   logic       do_write;     // Address and data both present
   logic [9:0] wr_index;     // Word index of the write
   logic [7:0] wr_byte;      // Low byte of the write, zero if unstrobed
   logic       wr_hit;       // Write index is mapped
   logic [7:0] sw_st_clr;    // Software clear mask of status
   logic [7:0] sw_st_set;    // Software set mask of status
   logic [6:0] sw_if_clr;    // Software clear mask of flags
   logic [6:0] sw_en_clr;    // Software clear mask of enables
   logic [6:0] sw_en_set;    // Software set mask of enables
   logic [6:0] hw_events;    // Flags raised by the engine this cycle
   logic [7:0] stall_clr;    // Stall bits dropped on SETUP
   logic [9:0] rd_index;     // Word index of the read
   logic [7:0] rd_byte;      // Read data before registering
   logic       rd_hit;       // Read index is mapped

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshakes and decode
   always_comb begin
      aw_fire  = s_axi_awvalid_i && st.awready;
      w_fire   = s_axi_wvalid_i && st.wready;
      ar_fire  = s_axi_arvalid_i && st.arready;
      // Write proceeds once both halves are in, even in the same cycle
      do_write = (st.aw_held || aw_fire) && (st.w_held || w_fire) && !st.bvalid;
      wr_index = st.aw_held ? st.aw_index : s_axi_awaddr_i[11:2];
      if (st.w_held) begin
         wr_byte = st.w_lane0 ? st.w_data : 8'h00;
      end else begin
         wr_byte = s_axi_wstrb_i[0] ? s_axi_wdata_i[7:0] : 8'h00;
      end
      unique case (wr_index)
         `EP_IDX_STATUS_CLEAR, `EP_IDX_STATUS_SET, `EP_IDX_STATUS,
         `EP_IDX_IRQ_FLAGS, `EP_IDX_IRQ_ENABLE_CLEAR,
         `EP_IDX_IRQ_ENABLE_SET, `EP_IDX_IRQ_SUMMARY: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software write masks; writes of zero leave every bit alone
   always_comb begin
      sw_st_clr = 8'h00;
      sw_st_set = 8'h00;
      sw_if_clr = 7'h00;
      sw_en_clr = 7'h00;
      sw_en_set = 7'h00;
      if (do_write) begin
         unique case (wr_index)
            `EP_IDX_STATUS_CLEAR: sw_st_clr = wr_byte & `EP_ST_IMPL_MASK;
            `EP_IDX_STATUS_SET:   sw_st_set = wr_byte & `EP_ST_IMPL_MASK;
            `EP_IDX_IRQ_FLAGS:    sw_if_clr = wr_byte[6:0];
            `EP_IDX_IRQ_ENABLE_CLEAR: sw_en_clr = wr_byte[6:0];
            `EP_IDX_IRQ_ENABLE_SET:   sw_en_set = wr_byte[6:0];
            default: begin
               // Read-only or unmapped: no side effect
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stall, fail and done events steered to the bank the current bank bit names
   always_comb begin
      hw_events = 7'h00;
      if (st.status[`EP_ST_CURRENT_BANK]) begin
         hw_events[`EP_IF_STALL_BANK1] = stall_sent_i;
         hw_events[`EP_IF_FAIL_BANK1]  = xfer_fail_i;
         hw_events[`EP_IF_DONE_BANK1]  = xfer_done_i;
      end else begin
         hw_events[`EP_IF_STALL_BANK0] = stall_sent_i;
         hw_events[`EP_IF_FAIL_BANK0]  = xfer_fail_i;
         hw_events[`EP_IF_DONE_BANK0]  = xfer_done_i;
      end
      hw_events[`EP_IF_SETUP] = setup_rx_i;
      stall_clr = 8'h00;
      // SETUP overrides any stall request, including one set this cycle
      stall_clr[`EP_ST_STALL_BANK1] = setup_rx_i;
      stall_clr[`EP_ST_STALL_BANK0] = setup_rx_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode; status set and clear registers read zero
   always_comb begin
      rd_index = st.arready ? s_axi_araddr_i[11:2] : 10'h000;
      rd_byte  = 8'h00;
      rd_hit   = 1'b1;
      unique case (rd_index)
         `EP_IDX_STATUS_CLEAR, `EP_IDX_STATUS_SET: rd_byte = 8'h00;
         `EP_IDX_STATUS:   rd_byte = st.status;
         `EP_IDX_IRQ_FLAGS: rd_byte = {1'b0, st.flags};
         `EP_IDX_IRQ_ENABLE_CLEAR, `EP_IDX_IRQ_ENABLE_SET:
            rd_byte = {1'b0, st.enable};
         `EP_IDX_IRQ_SUMMARY: rd_byte = {7'h00, st.irq};
         default: rd_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_st = st;
      // Write address and data capture
      if (aw_fire && !do_write) begin
         next_st.aw_held  = 1'b1;
         next_st.aw_index = s_axi_awaddr_i[11:2];
      end
      if (w_fire && !do_write) begin
         next_st.w_held  = 1'b1;
         next_st.w_data  = s_axi_wdata_i[7:0];
         next_st.w_lane0 = s_axi_wstrb_i[0];
      end
      if (do_write) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (st.bvalid && s_axi_bready_i) begin
         next_st.bvalid = 1'b0;
      end
      // Channels stay closed while their half is held or a response waits
      next_st.awready = !next_st.aw_held && !next_st.bvalid;
      next_st.wready  = !next_st.w_held && !next_st.bvalid;
      // Read channel
      if (ar_fire) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_byte;
         next_st.rresp  = rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (st.rvalid && s_axi_rready_i) begin
         next_st.rvalid = 1'b0;
      end
      next_st.arready = !next_st.rvalid;
      // Status: engine sets win over software clears
      next_st.status = ((st.status & ~sw_st_clr & ~status_hw_clr_i)
                        | sw_st_set | status_hw_set_i)
                       & ~stall_clr & `EP_ST_IMPL_MASK;
      // Flags: an event in the clearing cycle survives
      next_st.flags = (st.flags & ~sw_if_clr) | hw_events;
      // Enables share one store behind set and clear registers
      if (usb_bus_reset_i || !endpoint_enable_vector_i) begin
         next_st.enable = `EP_ENABLE_RESET;
      end else begin
         next_st.enable = (st.enable & ~sw_en_clr) | sw_en_set;
      end
      // Registered from next values so it tracks the stored flags exactly
      next_st.irq = |(next_st.flags & next_st.enable);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; ce_i low freezes everything
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st         <= '0;
         st.awready <= 1'b1;
         st.wready  <= 1'b1;
         st.arready <= 1'b1;
         st.status  <= `EP_STATUS_RESET;
         st.flags   <= `EP_FLAGS_RESET;
         st.enable  <= `EP_ENABLE_RESET;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all taken from the state register
   assign s_axi_awready_o       = st.awready;
   assign s_axi_wready_o        = st.wready;
   assign s_axi_bvalid_o        = st.bvalid;
   assign s_axi_bresp_o         = st.bresp;
   assign s_axi_arready_o       = st.arready;
   assign s_axi_rvalid_o        = st.rvalid;
   assign s_axi_rdata_o         = {24'h00_0000, st.rdata};
   assign s_axi_rresp_o         = st.rresp;
   assign stall_request_o       = st.status[5:4];
   assign current_bank_select_o = st.status[`EP_ST_CURRENT_BANK];
   assign in_toggle_o           = st.status[`EP_ST_IN_TOGGLE];
   assign out_toggle_o          = st.status[`EP_ST_OUT_TOGGLE];
   assign bank_ready_o          = st.status[7:6];
   assign endpoint_irq_o        = st.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions; cycles with ce_i low do not count
   default clocking cb @(posedge core_clk_i iff ce_i); endclocking
   default disable iff (rst_i);

   property p_sw_clear;
      sw_st_clr[`EP_ST_CURRENT_BANK] && !status_hw_set_i[`EP_ST_CURRENT_BANK]
         |=> !current_bank_select_o;
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("status clear lost");

   property p_sw_set;
      sw_st_set[`EP_ST_IN_TOGGLE] |=> in_toggle_o;
   endproperty
   a_sw_set: assert property (p_sw_set) else $error("status set lost");

   property p_ready_clear;
      sw_st_clr[7] && !status_hw_set_i[7] && !sw_st_set[7] |=> !bank_ready_o[1];
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("ready clear lost");

   property p_setup_unstall;
      setup_rx_i |=> stall_request_o == 2'b00 && endpoint_irq_o == |(st.flags & st.enable);
   endproperty
   a_setup_unstall: assert property (p_setup_unstall) else $error("stall kept");

   property p_bank0_flags;
      xfer_done_i && !current_bank_select_o |=> st.flags[`EP_IF_DONE_BANK0];
   endproperty
   a_bank0_flags: assert property (p_bank0_flags) else $error("bank0 flag missed");

   property p_bank1_stall;
      stall_sent_i && current_bank_select_o |=> st.flags[`EP_IF_STALL_BANK1];
   endproperty
   a_bank1_stall: assert property (p_bank1_stall) else $error("stall flag missed");

   property p_flag_keeps;
      st.flags[`EP_IF_SETUP] && !sw_if_clr[`EP_IF_SETUP] |=> st.flags[`EP_IF_SETUP];
   endproperty
   a_flag_keeps: assert property (p_flag_keeps) else $error("flag dropped");

   property p_enable_reset;
      usb_bus_reset_i || !endpoint_enable_vector_i |=> st.enable == 7'h00;
   endproperty
   a_enable_reset: assert property (p_enable_reset) else $error("enable survived");

   property p_irq_gate;
      endpoint_irq_o == |(st.flags & st.enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch");

   property p_write_answer;
      do_write |=> s_axi_bvalid_o ##0 (s_axi_awready_o == 1'b0);
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write response");

   property p_read_answer;
      ar_fire |=> s_axi_rvalid_o && !s_axi_arready_o;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("no read response");

   // Flags against the events that raise them and the writes that drop them
   property p_setup_flag;
      setup_rx_i |=> st.flags[`EP_IF_SETUP];
   endproperty
   a_setup_flag: assert property (p_setup_flag) else $error("setup flag missed");

   property p_bank1_fail;
      xfer_fail_i && current_bank_select_o |=> st.flags[`EP_IF_FAIL_BANK1];
   endproperty
   a_bank1_fail: assert property (p_bank1_fail) else $error("fail flag missed");

   property p_bank1_done;
      xfer_done_i && current_bank_select_o |=> st.flags[`EP_IF_DONE_BANK1];
   endproperty
   a_bank1_done: assert property (p_bank1_done) else $error("done flag missed");

   property p_flag_clear;
      sw_if_clr[`EP_IF_DONE_BANK0] && !hw_events[`EP_IF_DONE_BANK0]
         |=> !st.flags[`EP_IF_DONE_BANK0];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");

   // Enables: set and clear share one store; reset and disable win
   property p_enable_clear;
      sw_en_clr[`EP_IF_SETUP] |=> !st.enable[`EP_IF_SETUP];
   endproperty
   a_enable_clear: assert property (p_enable_clear) else $error("enable kept");

   property p_enable_set;
      sw_en_set[`EP_IF_SETUP] && endpoint_enable_vector_i && !usb_bus_reset_i
         |=> st.enable[`EP_IF_SETUP];
   endproperty
   a_enable_set: assert property (p_enable_set) else $error("enable set lost");

   // Independent of the gate above: an enabled event must reach the pin
   property p_irq_event;
      xfer_done_i && !current_bank_select_o && st.enable[`EP_IF_DONE_BANK0]
         && endpoint_enable_vector_i && !usb_bus_reset_i && !sw_en_clr[`EP_IF_DONE_BANK0]
         |=> endpoint_irq_o;
   endproperty
   a_irq_event: assert property (p_irq_event) else $error("irq not raised");

   c_setup_irq: cover property (setup_rx_i ##1 endpoint_irq_o);
   c_write_resp: cover property (do_write ##1 s_axi_bvalid_o && s_axi_bready_i);
   c_read_status: cover property (ar_fire && rd_index == `EP_IDX_STATUS ##1 s_axi_rvalid_o);
   c_flag_race: cover property (xfer_done_i && sw_if_clr != 7'h00);

endmodule : usb_device_endpoint_status_irq

//--- core/usb_ep_defines.svh
/*
 * Offsets, field positions, reset values and bus codes of the endpoint
 * status and interrupt register bank.
 * Assumes the includer uses these as sized values; holds definitions only.
 */
`ifndef USB_EP_DEFINES_SVH
`define USB_EP_DEFINES_SVH

// Register indices; byte address is four times the index
`define EP_IDX_STATUS_CLEAR     10'h104
`define EP_IDX_STATUS_SET       10'h105
`define EP_IDX_STATUS           10'h106
`define EP_IDX_IRQ_FLAGS        10'h107
`define EP_IDX_IRQ_ENABLE_CLEAR 10'h108
`define EP_IDX_IRQ_ENABLE_SET   10'h109
`define EP_IDX_IRQ_SUMMARY      10'h020

// Endpoint status field positions
`define EP_ST_BANK1_READY       7
`define EP_ST_BANK0_READY       6
`define EP_ST_STALL_BANK1       5
`define EP_ST_STALL_BANK0       4
`define EP_ST_CURRENT_BANK      2
`define EP_ST_IN_TOGGLE         1
`define EP_ST_OUT_TOGGLE        0
// Bit 3 is reserved and reads zero
`define EP_ST_IMPL_MASK         8'hF7

// Interrupt flag and enable field positions
`define EP_IF_STALL_BANK1       6
`define EP_IF_STALL_BANK0       5
`define EP_IF_SETUP             4
`define EP_IF_FAIL_BANK1        3
`define EP_IF_FAIL_BANK0        2
`define EP_IF_DONE_BANK1        1
`define EP_IF_DONE_BANK0        0

// Reset values
`define EP_STATUS_RESET         8'h00
`define EP_FLAGS_RESET          7'h00
`define EP_ENABLE_RESET         7'h00

// AXI response codes
`define AXI_RESP_OKAY           2'h0
`define AXI_RESP_SLVERR         2'h2

`endif

//--- core/usb_ep_pkg.sv
/*
 * Types of the endpoint status and interrupt register bank.
 * Assumes usb_ep_defines.svh is available on the include path.
 */
package usb_ep_pkg;

   // Whole state of the bank, registered as one word
   typedef struct packed {
      logic       awready;   // Write address channel ready
      logic       wready;    // Write data channel ready
      logic       aw_held;   // Write address taken, waiting for data
      logic [9:0] aw_index;  // Held word index
      logic       w_held;    // Write data taken, waiting for address
      logic [7:0] w_data;    // Held low byte
      logic       w_lane0;   // Held strobe of the low byte
      logic       bvalid;    // Write response pending
      logic [1:0] bresp;     // Write response code
      logic       arready;   // Read address channel ready
      logic       rvalid;    // Read response pending
      logic [7:0] rdata;     // Read data low byte
      logic [1:0] rresp;     // Read response code
      logic [7:0] status;    // Endpoint status bits
      logic [6:0] flags;     // Endpoint interrupt flags
      logic [6:0] enable;    // Endpoint interrupt enables
      logic       irq;       // Endpoint interrupt request
   } ep_state_t;

endpackage : usb_ep_pkg

//--- tb/usb_engine_model.sv
/*
 * Behavioural stand-in for the protocol engine that feeds the endpoint bank.
 * Assumes the bench raises each request for one cycle; every request becomes
 * a one-cycle strobe on the next clock, as the engine would issue it.
 */
`timescale 1ns/1ps

module usb_engine_model (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // Requests from the bench
   input  wire logic [3:0] ev_req_i,
   input  wire logic [7:0] set_req_i,
   input  wire logic [7:0] clr_req_i,
   // Strobes towards the bank
   output logic            setup_rx_o,
   output logic            stall_sent_o,
   output logic            xfer_fail_o,
   output logic            xfer_done_o,
   output logic [7:0]      status_hw_set_o,
   output logic [7:0]      status_hw_clr_o
);
   // Registered strobes, each one clock behind its request and as long
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         {setup_rx_o, stall_sent_o, xfer_fail_o, xfer_done_o} <= 4'h0;
         {status_hw_set_o, status_hw_clr_o} <= 16'h0000;
      end else begin
         {setup_rx_o, stall_sent_o, xfer_fail_o, xfer_done_o} <= ev_req_i;
         status_hw_set_o <= set_req_i;
         status_hw_clr_o <= clr_req_i;
      end
   end
endmodule : usb_engine_model

//--- tb/testbench.sv
/*
 * Self-checking bench of the endpoint status and interrupt bank.
 * Assumes a master on AXI4-Lite and the engine model as event source.
 */
`timescale 1ns/1ps

module testbench;
   // Bench stimulus
   logic        core_clk = 0, rst = 1, bus_rst = 0, ep_en = 1, ce = 1;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, got;
   logic [3:0]  wstrb = 0, ev = 0;
   logic [7:0]  hs = 0, hc = 0;
   logic [1:0]  rsp;
   // Design outputs and engine strobes
   wire logic        awready, wready, bvalid, arready, rvalid, irq, cb, tin, tout;
   wire logic        setup, stall, fail, done;
   wire logic [1:0]  bresp, rresp, stq, brdy;
   wire logic [31:0] rdata;
   wire logic [7:0]  hws, hwc;
   // Reference model and counters
   int          errors = 0, n_tests = 0, st = 0, fl = 0, en = 0, r;
   logic [9:0]  tbl [6] = '{10'h104, 10'h105, 10'h106, 10'h107, 10'h108, 10'h109};

   usb_engine_model i_eng (.core_clk_i(core_clk), .rst_i(rst), .ev_req_i(ev),
      .set_req_i(hs), .clr_req_i(hc), .setup_rx_o(setup), .stall_sent_o(stall),
      .xfer_fail_o(fail), .xfer_done_o(done), .status_hw_set_o(hws), .status_hw_clr_o(hwc));

   // Every design input comes from the bench or the engine model
   usb_device_endpoint_status_irq i_dut (.core_clk_i(core_clk), .rst_i(rst), .ce_i(ce),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .usb_bus_reset_i(bus_rst),
      .endpoint_enable_vector_i(ep_en), .setup_rx_i(setup), .stall_sent_i(stall),
      .xfer_fail_i(fail), .xfer_done_i(done), .status_hw_set_i(hws),
      .status_hw_clr_i(hwc), .stall_request_o(stq), .current_bank_select_o(cb),
      .in_toggle_o(tin), .out_toggle_o(tout), .bank_ready_o(brdy), .endpoint_irq_o(irq));

   ////////////////////////////////////////////////////////////////////////////
   // One comparison, counted
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         n_tests++;
         if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask : chk

   // Write; each channel released at the rising edge that takes it
   task wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      begin
         @(posedge core_clk);
         {awvalid, wvalid, bready} <= 3'h7;
         awaddr <= {idx, 2'b00};
         // Upper lanes random; the bank must ignore them
         wdata <= {24'($urandom), d};
         wstrb <= 4'hf;
         // Ends once bvalid is seen high at a rising edge
         do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while (!bvalid);
         rsp = bresp;
         bready <= 1'b0;
         chk(32'(rsp), 32'(er));
      end
   endtask : wr

   // Read; data taken at the rising edge where rvalid is seen high
   task rd(input logic [9:0] idx, input logic [1:0] er);
      begin
         @(posedge core_clk);
         {arvalid, rready} <= 2'h3;
         araddr <= {idx, 2'b00};
         do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
         end while (!rvalid);
         got = rdata;
         rsp = rresp;
         rready <= 1'b0;
         chk(32'(rsp), 32'(er));
      end
   endtask : rd

   // Software write plus its effect on the model
   task op(input logic [9:0] idx, input logic [7:0] d);
      begin
         wr(idx, d, 2'h0);
         case (idx)
            10'h104: st = st & ~int'(d);
            10'h105: st = st | int'(d & 8'hf7);
            10'h107: fl = fl & ~int'(d);
            10'h108: en = en & ~int'(d);
            10'h109: if (ep_en && !bus_rst) en = en | int'(d & 8'h7f);
            default: ;
         endcase
      end
   endtask : op

   // Engine event: 0 done, 1 fail, 2 stall sent, 3 setup
   task ev_pulse(input int k);
      int c;
      begin
         c = (st >> 2) & 1;
         @(posedge core_clk);
         ev <= 4'(1 << k);
         @(posedge core_clk);
         ev <= 4'h0;
         repeat (2) @(posedge core_clk);
         case (k)
            0: fl = fl | (1 << c);
            1: fl = fl | (4 << c);
            2: fl = fl | (32 << c);
            default: begin
               fl = fl | 16;
               st = st & ~8'h30;
            end
         endcase
      end
   endtask : ev_pulse

   // Engine set and clear strobes of status, never on the same bit
   task hw_pulse(input logic [7:0] s, input logic [7:0] c);
      begin
         @(posedge core_clk);
         hs <= s & ~c & 8'hf7;
         hc <= c;
         @(posedge core_clk);
         {hs, hc} <= 16'h0000;
         repeat (2) @(posedge core_clk);
         st = (st | int'(s & ~c & 8'hf7)) & ~int'(c);
      end
   endtask : hw_pulse

   // Every readable place but the status set and clear registers, and every status output, against the model
   task chk_all;
      begin
         rd(10'h106, 2'h0);
         chk(got, 32'(st));
         rd(10'h107, 2'h0);
         chk(got, 32'(fl));
         rd(10'h108, 2'h0);
         chk(got, 32'(en));
         rd(10'h109, 2'h0);
         chk(got, 32'(en));
         rd(10'h020, 2'h0);
         chk(got, 32'((fl & en) != 0));
         chk(32'({brdy, stq, 1'b0, cb, tin, tout}), 32'(st));
         chk(32'(irq), 32'((fl & en) != 0));
      end
   endtask : chk_all

   task final_report;
      begin
         $display("errors=%0d n_tests=%0d", errors, n_tests);
         if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog, far above the expected run
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      final_report;
   end

   // Main sequence
   initial begin
      got = $urandom(32'hfe66eac0);
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      chk_all;
      // Unmapped index refused both ways, no effect
      rd(10'h3ff, 2'h2);
      wr(10'h3ff, 8'hff, 2'h2);
      op(10'h105, 8'hff);
      chk_all;
      op(10'h104, 8'hf0);
      op(10'h104, 8'h07);
      op(10'h109, 8'h7f);
      chk_all;
      // Each event on both banks; setup must also drop stall requests
      for (int k = 0; k < 4; k++) begin
         for (int c = 0; c < 2; c++) begin
            op(c ? 10'h105 : 10'h104, 8'h04);
            op(10'h105, 8'h30);
            ev_pulse(k);
            chk_all;
         end
      end
      // Random mix of writes, events and engine strobes
      for (int i = 0; i < 40; i++) begin
         r = $urandom_range(0, 7);
         if (r < 6) op(tbl[r], 8'($urandom));
         else if (r == 6) ev_pulse($urandom_range(0, 3));
         else hw_pulse(8'($urandom), 8'($urandom));
         chk_all;
      end
      // Clock enable low freezes the bank: a done strobe is lost
      @(posedge core_clk);
      ce <= 1'b0;
      ev <= 4'h1;
      @(posedge core_clk);
      ev <= 4'h0;
      repeat (2) @(posedge core_clk);
      ce <= 1'b1;
      chk_all;
      // Bus reset and endpoint off both clear enables
      op(10'h109, 8'h7f);
      @(posedge core_clk);
      bus_rst <= 1'b1;
      @(posedge core_clk);
      bus_rst <= 1'b0;
      en = 0;
      chk_all;
      op(10'h109, 8'h7f);
      @(posedge core_clk);
      ep_en <= 1'b0;
      @(posedge core_clk);
      en = 0;
      op(10'h109, 8'h7f);
      chk_all;
      final_report;
   end
endmodule : testbench
